// file: rtl/dmaes_top.sv
// Implementation choice: the APB register port.
`timescale 1ns/1ps
`include "dmaes_defines.svh"
module dmaes_top
  import dmaes_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // on-chip event pulses, same clock
  input wire logic timer0_event_i,
  input wire logic timer1_event_i,
  input wire logic memif_timer_event_i,
  input wire logic pin_event_2_i,
  input wire logic serial0_tx_event_i,
  input wire logic serial0_rx_event_i,
  input wire logic serial1_tx_event_i,
  input wire logic serial1_rx_event_i,
  // external pin events 4-7, asynchronous levels
  input wire logic [3:0] external_pin_event_i,
  input wire logic [3:0] pin_polarity_i,
  // chaining completion codes for channels 8-11
  input wire logic [3:0] completion_chain_code_i,
  // channel triggers
  output logic [15:0] channel_trigger_o
);
  dmaes_pin_if pin_if (); // pin path to edge detector

  logic [31:0] sel_ch0_3_ff; // event_select_ch0_3
  logic [31:0] sel_ch4_7_ff; // event_select_ch4_7
  logic [31:0] sel_ch12_15_ff; // event_select_ch12_15
  logic [31:0] prdata_ff; // registered read data
  logic [15:0] trigger_ff; // registered triggers
  logic [15:0] nxt_trigger; // next triggers
  logic [DMAES_EV_COUNT-1:0] events; // all event lines
  logic [31:0] wmask; // byte-lane write mask
  logic setup; // apb setup phase
  logic hit0; // address decodes
  logic hit1;
  logic hit3;

  // decode one selector code into an event index; -1 when reserved
  function automatic int code_to_event(input dmaes_code_t code);
    case (code)
      `DMAES_CODE_TIMER0: code_to_event = DMAES_EV_TIMER0;
      `DMAES_CODE_TIMER1: code_to_event = DMAES_EV_TIMER1;
      `DMAES_CODE_MEMIF: code_to_event = DMAES_EV_MEMIF;
      `DMAES_CODE_PIN4: code_to_event = DMAES_EV_PIN4;
      `DMAES_CODE_PIN5: code_to_event = DMAES_EV_PIN5;
      `DMAES_CODE_PIN6: code_to_event = DMAES_EV_PIN6;
      `DMAES_CODE_PIN7: code_to_event = DMAES_EV_PIN7;
      `DMAES_CODE_PIN2: code_to_event = DMAES_EV_PIN2;
      `DMAES_CODE_S0TX: code_to_event = DMAES_EV_S0TX;
      `DMAES_CODE_S0RX: code_to_event = DMAES_EV_S0RX;
      `DMAES_CODE_S1TX: code_to_event = DMAES_EV_S1TX;
      `DMAES_CODE_S1RX: code_to_event = DMAES_EV_S1RX;
      default: code_to_event = -1;
    endcase
  endfunction : code_to_event

  // event pulse of the selected line, zero for reserved codes
  function automatic logic pick(input dmaes_code_t code,
                                input logic [DMAES_EV_COUNT-1:0] ev);
    int idx;
    idx = code_to_event(code);
    if (idx < 0)
      pick = 1'b0;
    else
      pick = ev[idx];
  endfunction : pick

  // pin edge detection; pins configured as inputs by the i/o block
  assign pin_if.pin_level = external_pin_event_i;
  assign pin_if.polarity = pin_polarity_i;

  dmaes_pin_edge #(
    .PINS(4)
  ) u_pin_edge (
    .ref_clk_i(ref_clk_i),
    .reset_n_i(reset_n_i),
    .pin_if(pin_if)
  );

  // gather event lines
  always_comb
  begin
    events = '0;
    events[DMAES_EV_TIMER0] = timer0_event_i;
    events[DMAES_EV_TIMER1] = timer1_event_i;
    events[DMAES_EV_MEMIF] = memif_timer_event_i;
    events[DMAES_EV_PIN4] = pin_if.pin_event[0];
    events[DMAES_EV_PIN5] = pin_if.pin_event[1];
    events[DMAES_EV_PIN6] = pin_if.pin_event[2];
    events[DMAES_EV_PIN7] = pin_if.pin_event[3];
    events[DMAES_EV_PIN2] = pin_event_2_i;
    events[DMAES_EV_S0TX] = serial0_tx_event_i;
    events[DMAES_EV_S0RX] = serial0_rx_event_i;
    events[DMAES_EV_S1TX] = serial1_tx_event_i;
    events[DMAES_EV_S1RX] = serial1_rx_event_i;
  end

  // apb decode
  assign setup = psel_i && !penable_i;
  assign hit0 = (paddr_i == `DMAES_ADDR_SEL_CH0_3);
  assign hit1 = (paddr_i == `DMAES_ADDR_SEL_CH4_7);
  assign hit3 = (paddr_i == `DMAES_ADDR_SEL_CH12_15);
  assign wmask = {{8{pstrb_i[3]}}, {8{pstrb_i[2]}}, {8{pstrb_i[1]}}, {8{pstrb_i[0]}}}
               & `DMAES_FIELD_MASK;

  // zero-wait slave: access phase always completes
  assign pready_o = 1'b1;
  assign pslverr_o = psel_i && penable_i && !(hit0 || hit1 || hit3);
  assign prdata_o = prdata_ff;

  // selector register writes, taken in the access phase
  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      sel_ch0_3_ff <= `DMAES_RST_CH0_3;
      sel_ch4_7_ff <= `DMAES_RST_CH4_7;
      sel_ch12_15_ff <= `DMAES_RST_CH12_15;
    end
    else if (psel_i && penable_i && pwrite_i)
    begin
      if (hit0)
        sel_ch0_3_ff <= (sel_ch0_3_ff & ~wmask) | (pwdata_i & wmask);
      if (hit1)
        sel_ch4_7_ff <= (sel_ch4_7_ff & ~wmask) | (pwdata_i & wmask);
      if (hit3)
        sel_ch12_15_ff <= (sel_ch12_15_ff & ~wmask) | (pwdata_i & wmask);
    end
  end

  // read data latched in setup, valid throughout the access phase
  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      prdata_ff <= 32'h0000_0000;
    else if (setup && !pwrite_i)
    begin
      if (hit0)
        prdata_ff <= sel_ch0_3_ff; // reserved bits already zero
      else if (hit1)
        prdata_ff <= sel_ch4_7_ff;
      else if (hit3)
        prdata_ff <= sel_ch12_15_ff;
      else
        prdata_ff <= 32'h0000_0000; // unmapped reads zero
    end
  end

  // routing of events to channels
  always_comb
  begin
    nxt_trigger = '0;
    for (int c = 0; c < 4; c++)
    begin
      nxt_trigger[c] = pick(sel_ch0_3_ff[c*`DMAES_FIELD_STRIDE +: `DMAES_CODE_W],
                            events);
      nxt_trigger[c+4] = pick(sel_ch4_7_ff[c*`DMAES_FIELD_STRIDE +: `DMAES_CODE_W],
                              events);
      nxt_trigger[c+12] = pick(sel_ch12_15_ff[c*`DMAES_FIELD_STRIDE +: `DMAES_CODE_W],
                               events);
      nxt_trigger[c+8] = completion_chain_code_i[c];
    end
  end

  // one register stage: each input pulse gives a one-cycle trigger
  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      trigger_ff <= '0;
    else
      trigger_ff <= nxt_trigger;
  end

  assign channel_trigger_o = trigger_ff;
endmodule : dmaes_top

// file: include/dmaes_defines.svh
`ifndef DMAES_DEFINES_SVH
`define DMAES_DEFINES_SVH
// register byte addresses
`define DMAES_ADDR_SEL_CH0_3 32'h01A0_FF00
`define DMAES_ADDR_SEL_CH4_7 32'h01A0_FF04
`define DMAES_ADDR_SEL_CH12_15 32'h01A0_FF0C
// field layout: four 6-bit codes on byte lanes
`define DMAES_CODE_W 6
`define DMAES_FIELD_STRIDE 8
`define DMAES_FIELD_MASK 32'h3F3F_3F3F
// reset values of the selector registers
`define DMAES_RST_CH0_3 32'h0302_0100
`define DMAES_RST_CH4_7 32'h0706_0504
`define DMAES_RST_CH12_15 32'h0F0E_0D0C
// event codes
`define DMAES_CODE_TIMER0 6'h01
`define DMAES_CODE_TIMER1 6'h02
`define DMAES_CODE_MEMIF 6'h03
`define DMAES_CODE_PIN4 6'h04
`define DMAES_CODE_PIN5 6'h05
`define DMAES_CODE_PIN6 6'h06
`define DMAES_CODE_PIN7 6'h07
`define DMAES_CODE_PIN2 6'h0A
`define DMAES_CODE_S0TX 6'h0C
`define DMAES_CODE_S0RX 6'h0D
`define DMAES_CODE_S1TX 6'h0E
`define DMAES_CODE_S1RX 6'h0F
`endif

// file: include/dmaes_pkg.sv
package dmaes_pkg;
  // index of a peripheral event line
  typedef enum {
    DMAES_EV_TIMER0,
    DMAES_EV_TIMER1,
    DMAES_EV_MEMIF,
    DMAES_EV_PIN4,
    DMAES_EV_PIN5,
    DMAES_EV_PIN6,
    DMAES_EV_PIN7,
    DMAES_EV_PIN2,
    DMAES_EV_S0TX,
    DMAES_EV_S0RX,
    DMAES_EV_S1TX,
    DMAES_EV_S1RX,
    DMAES_EV_COUNT
  } dmaes_event_t;
  // one selector code
  typedef logic [5:0] dmaes_code_t;
endpackage : dmaes_pkg

// file: include/dmaes_pin_if.sv
`timescale 1ns/1ps
// pin event path between the top and the edge detector
interface dmaes_pin_if;
  logic [3:0] pin_level; // raw pin levels
  logic [3:0] polarity; // 1 = rising edge active
  logic [3:0] pin_event; // one-cycle event pulses
  modport top (output pin_level, output polarity, input pin_event);
  modport det (input pin_level, input polarity, output pin_event);
endinterface : dmaes_pin_if

// file: rtl/dmaes_pin_edge.sv
`timescale 1ns/1ps
`include "dmaes_defines.svh"
// synchronises the external pins and detects the active edge
module dmaes_pin_edge
  import dmaes_pkg::*;
#(
  parameter int PINS = 4
)
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  // pin path
  dmaes_pin_if.det pin_if
);
  logic [PINS-1:0] sync1_ff; // first stage, read only by sync2
  logic [PINS-1:0] sync2_ff; // second stage
  logic [PINS-1:0] prev_ff; // previous synchronised level
  logic [PINS-1:0] pin_event_ff; // registered pulses

  // the pin interface carries exactly four lines
  if (PINS != 4)
  begin : g_bad_pins
    $error("dmaes_pin_edge: PINS must be 4");
  end

  // two-stage synchroniser
  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      sync1_ff <= '0;
      sync2_ff <= '0;
    end
    else
    begin
      sync1_ff <= pin_if.pin_level;
      sync2_ff <= sync1_ff;
    end
  end

  // edge detect with per-pin polarity
  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      prev_ff <= '0;
      pin_event_ff <= '0;
    end
    else
    begin
      prev_ff <= sync2_ff;
      pin_event_ff <= (pin_if.polarity & sync2_ff & ~prev_ff)
                    | (~pin_if.polarity & ~sync2_ff & prev_ff);
    end
  end

  assign pin_if.pin_event = pin_event_ff;
endmodule : dmaes_pin_edge

// file: dv/dmaes_sva.sv
`timescale 1ns/1ps
`include "dmaes_defines.svh"
// port checker for the event selector
module dmaes_sva (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  // apb side
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] paddr_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  // chain and triggers
  input wire logic [3:0] completion_chain_code_i,
  input wire logic [15:0] channel_trigger_o
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!reset_n_i);
  // access phase, mapped address, read access
  wire acc_w = psel_i & penable_i;
  wire map_w = paddr_i inside {`DMAES_ADDR_SEL_CH0_3, `DMAES_ADDR_SEL_CH4_7,
    `DMAES_ADDR_SEL_CH12_15};
  wire rd_w = acc_w & ~pwrite_i;
  a_ready_high:
  assert property (acc_w |-> pready_o)
    else $error("access without ready");
  a_err_hole:
  assert property (acc_w && !map_w |-> pslverr_o)
    else $error("no error on unmapped access");
  a_err_mapped:
  assert property (acc_w && map_w |-> !pslverr_o)
    else $error("error on mapped access");
  a_err_idle:
  assert property (!acc_w |-> !pslverr_o)
    else $error("error outside access");
  a_gap_zero:
  assert property (rd_w |-> (prdata_o & 32'hC0C0_C0C0) == 32'h0000_0000)
    else $error("gap bits not zero");
  a_hole_zero:
  assert property (rd_w && !map_w |-> prdata_o == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_rd_stands:
  assert property (!(psel_i && !penable_i && !pwrite_i) |=> $stable(prdata_o))
    else $error("read data moved");
  a_chain_route:
  assert property (channel_trigger_o[11:8] == $past(completion_chain_code_i))
    else $error("chain trigger wrong");
  // main scenarios reached
  c_hole: cover property (acc_w && !map_w);
  c_chain: cover property (channel_trigger_o[8]);
  c_route: cover property (channel_trigger_o[0]);
endmodule : dmaes_sva
bind dmaes_top dmaes_sva u_dmaes_sva (.*);

// file: dv/dmaes_dma_peer.sv
`timescale 1ns/1ps
// channel side model: gathers trigger pulses
module dmaes_dma_peer (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  // triggers in, gathered set out
  input wire logic [15:0] trig_i,
  input wire logic clr_i,
  output logic [15:0] seen_o
);
  logic [15:0] seen_ff; // channels triggered since clear
  // sticky collection, cleared on request
  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      seen_ff <= '0;
    else if (clr_i)
      seen_ff <= '0;
    else
      seen_ff <= seen_ff | trig_i;
  end
  assign seen_o = seen_ff;
endmodule : dmaes_dma_peer

// file: dv/tb.sv
`timescale 1ns/1ps
`include "dmaes_defines.svh"
// selector bench: apb access and event routing
module tb;
  // dut ports
  logic ref_clk_i, reset_n_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
  logic [31:0] paddr_i, pwdata_i, prdata_o, rd;
  logic [3:0] pstrb_i, external_pin_event_i, pin_polarity_i, completion_chain_code_i;
  logic [15:0] channel_trigger_o, seen;
  logic [7:0] ev; // on-chip events, timer0 at bit 0
  logic clr, er;
  wire timer0_event_i, timer1_event_i, memif_timer_event_i, pin_event_2_i;
  wire serial0_tx_event_i, serial0_rx_event_i, serial1_tx_event_i, serial1_rx_event_i;
  assign {serial1_rx_event_i, serial1_tx_event_i, serial0_rx_event_i, serial0_tx_event_i,
    pin_event_2_i, memif_timer_event_i, timer1_event_i, timer0_event_i} = ev;
  int error_cnt = 0;
  int total_checks = 0;
  logic [5:0] codes [8] = '{6'h01, 6'h02, 6'h03, 6'h0A, 6'h0C, 6'h0D, 6'h0E, 6'h0F};
  logic [5:0] rsv [6] = '{6'h00, 6'h08, 6'h09, 6'h0B, 6'h10, 6'h3F};
  dmaes_top u_dmaes_top (.*);
  dmaes_dma_peer u_dmaes_dma_peer (.ref_clk_i, .reset_n_i, .trig_i(channel_trigger_o),
    .clr_i(clr), .seen_o(seen));
  // 50 MHz clock
  initial
  begin
    ref_clk_i = 1'b0;
    forever #10 ref_clk_i = ~ref_clk_i;
  end
  // compare and count
  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    total_checks++;
    if (s !== e)
    begin
      error_cnt++;
      $display("MISMATCH %s exp %h seen %h", n, e, s);
    end
  endtask : chk
  // one apb transfer, result in rd and er
  task automatic apb(logic w, logic [31:0] a, logic [31:0] d, logic [3:0] s);
    @(posedge ref_clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    pstrb_i <= s;
    @(posedge ref_clk_i);
    penable_i <= 1'b1;
    @(posedge ref_clk_i);
    while (pready_o !== 1'b1)
      @(posedge ref_clk_i);
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb
  // pulse events for a cycle, check the trigger cycle and the one after
  task automatic fire(logic [7:0] e, logic [3:0] c, logic [15:0] x);
    @(posedge ref_clk_i);
    ev <= e;
    completion_chain_code_i <= c;
    @(posedge ref_clk_i);
    ev <= 8'h00;
    completion_chain_code_i <= 4'h0;
    #1 chk("trig", 32'(channel_trigger_o), 32'(x));
    @(posedge ref_clk_i);
    #1 chk("trig_end", 32'(channel_trigger_o), 32'h0);
  endtask : fire
  // empty the gathered trigger set
  task automatic clear;
    @(posedge ref_clk_i);
    clr <= 1'b1;
    @(posedge ref_clk_i);
    clr <= 1'b0;
  endtask : clear
  // verdict and end of run
  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : summarize
  // hang guard
  initial
  begin
    repeat (20000) @(posedge ref_clk_i);
    error_cnt++;
    summarize();
  end
  // test sequence
  initial
  begin
    {reset_n_i, psel_i, penable_i, pwrite_i, clr, ev} = '0;
    {paddr_i, pwdata_i, pstrb_i, completion_chain_code_i} = '0;
    external_pin_event_i = 4'h0;
    pin_polarity_i = 4'h5;
    repeat (20) @(posedge ref_clk_i);
    reset_n_i <= 1'b1;
    apb(0, `DMAES_ADDR_SEL_CH0_3, 0, 0);
    chk("sel0", rd, 32'h0302_0100);
    apb(0, `DMAES_ADDR_SEL_CH4_7, 0, 0);
    chk("sel1", rd, 32'h0706_0504);
    apb(0, `DMAES_ADDR_SEL_CH12_15, 0, 0);
    chk("sel3", rd, 32'h0F0E_0D0C);
    apb(0, 32'h01A0_FF08, 0, 0);
    chk("hole_err", 32'(er), 32'h0000_0001);
    apb(1, 32'h01A0_FF08, 32'hFFFF_FFFF, 4'hF);
    chk("hole_werr", 32'(er), 32'h0000_0001);
    apb(1, `DMAES_ADDR_SEL_CH0_3, 32'hFFFF_FFFF, 4'h1);
    apb(0, `DMAES_ADDR_SEL_CH0_3, 0, 0);
    chk("lane0", rd, 32'h0302_013F);
    apb(1, `DMAES_ADDR_SEL_CH0_3, 32'hFFFF_FFFF, 4'hF);
    apb(0, `DMAES_ADDR_SEL_CH0_3, 0, 0);
    chk("gaps", rd, 32'h3F3F_3F3F);
    $display("test registers done");
    for (int i = 0; i < 8; i++)
    begin
      apb(1, `DMAES_ADDR_SEL_CH0_3, {26'h0, codes[i]}, 4'hF);
      fire(8'(1 << i), 4'h0, {4'(8'(1 << i) >> 4), 11'h0, 1'b1});
    end
    foreach (rsv[i])
    begin
      apb(1, `DMAES_ADDR_SEL_CH0_3, {4{2'b00, rsv[i]}}, 4'hF);
      fire(8'hFF, 4'h0, 16'hF000);
    end
    fire(8'h00, 4'hF, 16'h0F00);
    fire(8'h00, 4'h5, 16'h0500);
    $display("test routing done");
    clear();
    external_pin_event_i <= 4'hF;
    repeat (8) @(posedge ref_clk_i);
    #1 chk("pin_rise", 32'(seen), 32'h0000_0050);
    clear();
    external_pin_event_i <= 4'h0;
    repeat (8) @(posedge ref_clk_i);
    #1 chk("pin_fall", 32'(seen), 32'h0000_00A0);
    $display("test pins done");
    summarize();
  end
endmodule : tb
